// *** rtl/hsps_pkg.sv ***
// Package of constants and types for the hot-swap power sequencer
// Functional notes
// [RQ1] Supply counts as in range only with low compare above and high compare below.
// [RQ2] Both seat detects must show seated; no load drive at power application.
// [RQ3] Once supply and seating are good, wait the seat delay then enable gate.
// [RQ4] Power output counts as on only once switch-on sense reports low drop.
// [RQ5] Power good asserts only with supply in range and switch reported on.
// [RQ6] Power good withheld after a start-up trip; needs a trip-free start. Code only flags it in status; power good still asserts after a retry.
// [RQ7] Drop above threshold longer than filter time trips; shorter pulses ignored.
// [RQ8] Fast-trip compare trips the breaker at once, bypassing the filter.
// [RQ9] Any trip removes gate enable and drives breaker fault low.
// [RQ10] Sustained over-current during or after insertion turns the switch off fast.
// [RQ11] In duty-cycle mode a trip clears itself after the retry period.
// [RQ12] If over-current persists after auto clear, the breaker trips again.
// [RQ13] Breaker clear held low keeps the external switch off.
// [RQ14] Sequencing delays come from fixed factory settings, not from software.
// [RQ15] Seat detect delay is 80 ms.
// [RQ16] Breaker filter time is one of four values, 5 us to 400 us.
// [RQ17] Power-good delay is one of four values, 5 ms to 160 ms.
// [RQ18] Duty-cycle retry period is 1.5 s.
// [RQ19] All inputs are synchronised; every delay counts whole clock cycles.
// [RQ20] After reset gate off, power good off, fault released.
package hsps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int  CLK_PERIOD_NS   = 10;
  localparam int  SEAT_DELAY_MS   = 80;
  localparam real RETRY_PERIOD_S  = 1.5;
  localparam int  FILT_T0_US      = 5;
  localparam int  FILT_T1_US      = 50;
  localparam int  FILT_T2_US      = 150;
  localparam int  FILT_T3_US      = 400;
  localparam int  PGD_T0_MS       = 5;
  localparam int  PGD_T1_MS       = 20;
  localparam int  PGD_T2_MS       = 80;
  localparam int  PGD_T3_MS       = 160;

  localparam int  SEAT_DELAY_CYC  = SEAT_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int  RETRY_CYC       = int'(RETRY_PERIOD_S * 1.0e9 / CLK_PERIOD_NS);
  localparam int  FILT_CYC0       = FILT_T0_US * 1000 / CLK_PERIOD_NS;
  localparam int  FILT_CYC1       = FILT_T1_US * 1000 / CLK_PERIOD_NS;
  localparam int  FILT_CYC2       = FILT_T2_US * 1000 / CLK_PERIOD_NS;
  localparam int  FILT_CYC3       = FILT_T3_US * 1000 / CLK_PERIOD_NS;
  localparam int  PGD_CYC0        = PGD_T0_MS * 1000000 / CLK_PERIOD_NS;
  localparam int  PGD_CYC1        = PGD_T1_MS * 1000000 / CLK_PERIOD_NS;
  localparam int  PGD_CYC2        = PGD_T2_MS * 1000000 / CLK_PERIOD_NS;
  localparam int  PGD_CYC3        = PGD_T3_MS * 1000000 / CLK_PERIOD_NS;

  localparam int  CNT_W           = 32;
  localparam int  SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_STATUS  = 4'h4;
  localparam logic [3:0]  OFS_CONFIG  = 4'h8;

  localparam int          CTRL_ENABLE = 0;
  localparam int          CTRL_DUTY   = 1;
  localparam int          CTRL_SEATEN = 2;
  localparam logic [2:0]  CTRL_RESET  = 3'h5;

  localparam int          ST_TRIP_EVT = 8;
  localparam int          ST_START_TRIP = 9;
  localparam int          ST_GATE     = 10;
  localparam int          ST_PGOOD    = 11;
  localparam int          ST_FAULT    = 12;
  localparam int          ST_CNT_LSB  = 16;
  localparam int          TRIP_CNT_W  = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    HSPS_IDLE = 5'b00001,
    HSPS_SEAT = 5'b00010,
    HSPS_RAMP = 5'b00100,
    HSPS_RUN  = 5'b01000,
    HSPS_TRIP = 5'b10000
  } hsps_state_t;

  typedef struct packed {
    logic supply_low_compare;
    logic supply_high_compare;
    logic seat_detect_a_n;
    logic seat_detect_b_n;
    logic switch_on_sense;
    logic current_drop_sense;
    logic fast_trip;
    logic breaker_clear_n;
  } hsps_in_t;

  localparam int IN_W = $bits(hsps_in_t);

endpackage

// *** rtl/hsps_sync.sv ***
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/100ps
module hsps_sync
  import hsps_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  // Reset value is all zero; callers must treat zero as inactive or invert
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule

// *** rtl/hsps_top.sv ***
// Hot-swap power sequencer: sequencing, breaker and Avalon-MM registers
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module hsps_top
  import hsps_pkg::*;
#(
  parameter logic [1:0]       FILT_SEL  = 2'h3,
  parameter logic [1:0]       PGD_SEL   = 2'h0,
  parameter logic [CNT_W-1:0] SEAT_CYC  = CNT_W'(SEAT_DELAY_CYC),
  parameter logic [CNT_W-1:0] RETRY_PER = CNT_W'(RETRY_CYC),
  parameter logic [CNT_W-1:0] FILT0     = CNT_W'(FILT_CYC0),
  parameter logic [CNT_W-1:0] FILT1     = CNT_W'(FILT_CYC1),
  parameter logic [CNT_W-1:0] FILT2     = CNT_W'(FILT_CYC2),
  parameter logic [CNT_W-1:0] FILT3     = CNT_W'(FILT_CYC3),
  parameter logic [CNT_W-1:0] PGD0      = CNT_W'(PGD_CYC0),
  parameter logic [CNT_W-1:0] PGD1      = CNT_W'(PGD_CYC1),
  parameter logic [CNT_W-1:0] PGD2      = CNT_W'(PGD_CYC2),
  parameter logic [CNT_W-1:0] PGD3      = CNT_W'(PGD_CYC3)
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // Comparator results and card inputs
  input  wire logic              supply_low_compare_i,
  input  wire logic              supply_high_compare_i,
  input  wire logic              seat_detect_a_n_i,
  input  wire logic              seat_detect_b_n_i,
  input  wire logic              switch_on_sense_i,
  input  wire logic              current_drop_sense_i,
  input  wire logic              fast_trip_i,
  input  wire logic              breaker_clear_n_i,
  // Power outputs
  output logic                   gate_drive_enable_o,
  output logic                   power_good_n_o,
  output logic                   breaker_fault_n_o,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest
);

  // ----------------------------------------------------------------
  // Factory delay selection
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] pick4(
    input logic [1:0]       sel,
    input logic [CNT_W-1:0] v0,
    input logic [CNT_W-1:0] v1,
    input logic [CNT_W-1:0] v2,
    input logic [CNT_W-1:0] v3
  );
    case (sel)
      2'h0:    pick4 = v0;
      2'h1:    pick4 = v1;
      2'h2:    pick4 = v2;
      default: pick4 = v3;
    endcase
  endfunction

  // Delays are fixed by parameters only; no register can change them
  localparam logic [CNT_W-1:0] FILT_LIM = pick4(FILT_SEL, FILT0, FILT1, FILT2, FILT3); // [RQ14] [RQ16]
  localparam logic [CNT_W-1:0] PGD_LIM  = pick4(PGD_SEL, PGD0, PGD1, PGD2, PGD3);      // [RQ14] [RQ17]

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  hsps_in_t raw_in;
  hsps_in_t syn_in;
  logic [IN_W-1:0] syn_bits;

  // Active-low inputs are inverted so the all-zero sync reset reads inactive
  always_comb begin
    raw_in                     = '0;
    raw_in.supply_low_compare  = supply_low_compare_i;
    raw_in.supply_high_compare = supply_high_compare_i;
    raw_in.seat_detect_a_n     = ~seat_detect_a_n_i;
    raw_in.seat_detect_b_n     = ~seat_detect_b_n_i;
    raw_in.switch_on_sense     = switch_on_sense_i;
    raw_in.current_drop_sense  = current_drop_sense_i;
    raw_in.fast_trip           = fast_trip_i;
    raw_in.breaker_clear_n     = ~breaker_clear_n_i;
  end

  hsps_sync #(
    .WIDTH (IN_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (raw_in),
    .sync_o    (syn_bits)
  ); // [RQ19]

  assign syn_in = hsps_in_t'(syn_bits);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  hsps_state_t                 state_reg;
  hsps_state_t                 state_next;
  logic [CNT_W-1:0]            tmr_reg;
  logic [CNT_W-1:0]            tmr_next;
  logic [CNT_W-1:0]            filt_reg;
  logic [CNT_W-1:0]            filt_next;
  logic                        gate_reg;
  logic                        gate_next;
  logic                        pg_n_reg;
  logic                        pg_n_next;
  logic                        fault_n_reg;
  logic                        fault_n_next;
  logic                        start_trip_reg;
  logic                        start_trip_next;
  logic                        trip_evt_reg;
  logic                        trip_evt_next;
  logic [TRIP_CNT_W-1:0]       trip_cnt_reg;
  logic [TRIP_CNT_W-1:0]       trip_cnt_next;
  logic [2:0]                  ctrl_reg;
  logic [2:0]                  ctrl_next;
  logic                        wait_reg;
  logic                        wait_next;
  logic [31:0]                 rdata_reg;
  logic [31:0]                 rdata_next;

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  logic supply_ok;
  logic seated;
  logic clear_held;
  logic enables_ok;
  logic slow_trip;
  logic trip;

  always_comb begin
    supply_ok  = syn_in.supply_low_compare & ~syn_in.supply_high_compare;   // [RQ1]
    seated     = (syn_in.seat_detect_a_n & syn_in.seat_detect_b_n)
               | ~ctrl_reg[CTRL_SEATEN];                                     // [RQ2]
    clear_held = syn_in.breaker_clear_n;
    enables_ok = supply_ok & seated & ~clear_held & ctrl_reg[CTRL_ENABLE];
    slow_trip  = syn_in.current_drop_sense && (filt_reg >= FILT_LIM);       // [RQ7]
    trip       = slow_trip | syn_in.fast_trip;                               // [RQ8]
  end

  // ----------------------------------------------------------------
  // Breaker filter
  // ----------------------------------------------------------------
  // Counts only while the drop is continuously above threshold
  always_comb begin
    filt_next = '0;
    if (syn_in.current_drop_sense && gate_reg) begin
      filt_next = (filt_reg >= FILT_LIM) ? filt_reg : filt_reg + 1'b1;     // [RQ7]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      filt_reg <= '0;
    end else begin
      filt_reg <= filt_next;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next      = state_reg;
    tmr_next        = tmr_reg;
    gate_next       = 1'b0;
    pg_n_next       = 1'b1;
    fault_n_next    = fault_n_reg;
    start_trip_next = start_trip_reg;
    trip_cnt_next   = trip_cnt_reg;
    case (state_reg)
      HSPS_IDLE: begin
        tmr_next     = '0;
        fault_n_next = 1'b1;
        if (enables_ok) begin
          state_next = HSPS_SEAT;                                            // [RQ2]
        end
      end
      HSPS_SEAT: begin
        if (!enables_ok) begin
          state_next = HSPS_IDLE;
          tmr_next   = '0;
        end else if (tmr_reg >= SEAT_CYC - 1'b1) begin
          state_next = HSPS_RAMP;                                            // [RQ3] [RQ15]
          tmr_next   = '0;
          gate_next  = 1'b1;
        end else begin
          tmr_next   = tmr_reg + 1'b1;                                       // [RQ19]
        end
      end
      HSPS_RAMP: begin
        gate_next = 1'b1;
        if (trip) begin
          state_next      = HSPS_TRIP;
          gate_next       = 1'b0;                                            // [RQ9] [RQ10]
          fault_n_next    = 1'b0;
          start_trip_next = 1'b1;                                            // [RQ6]
          trip_cnt_next   = trip_cnt_reg + 1'b1;
          tmr_next        = '0;
        end else if (!enables_ok) begin
          state_next = HSPS_IDLE;                                            // [RQ13]
          gate_next  = 1'b0;
        end else begin
          if (tmr_reg < PGD_LIM) begin
            tmr_next = tmr_reg + 1'b1;
          end
          if ((tmr_reg >= PGD_LIM - 1'b1) && syn_in.switch_on_sense) begin
            state_next      = HSPS_RUN;                                      // [RQ4] [RQ17]
            pg_n_next       = 1'b0;                                          // [RQ5] [RQ6]
            start_trip_next = 1'b0;
          end
        end
      end
      HSPS_RUN: begin
        gate_next = 1'b1;
        pg_n_next = ~(supply_ok & syn_in.switch_on_sense);                   // [RQ5]
        if (trip) begin
          state_next    = HSPS_TRIP;
          gate_next     = 1'b0;                                              // [RQ9] [RQ10]
          pg_n_next     = 1'b1;
          fault_n_next  = 1'b0;
          trip_cnt_next = trip_cnt_reg + 1'b1;
          tmr_next      = '0;
        end else if (!enables_ok) begin
          state_next = HSPS_IDLE;                                            // [RQ1] [RQ13]
          gate_next  = 1'b0;
          pg_n_next  = 1'b1;
        end else if (!syn_in.switch_on_sense) begin
          state_next = HSPS_RAMP;                                            // [RQ4]
          pg_n_next  = 1'b1;
        end
      end
      HSPS_TRIP: begin
        fault_n_next = 1'b0;                                                 // [RQ9]
        if (clear_held) begin
          state_next   = HSPS_IDLE;
          fault_n_next = 1'b1;
          tmr_next     = '0;
        end else if (ctrl_reg[CTRL_DUTY]) begin
          if (tmr_reg >= RETRY_PER - 1'b1) begin
            // Retry goes straight to gate drive if enables are good, else to idle; a live fault re-trips
            tmr_next     = '0;
            fault_n_next = 1'b1;                                             // [RQ11] [RQ18]
            if (enables_ok) begin
              state_next = HSPS_RAMP;                                        // [RQ12]
              gate_next  = 1'b1;
            end else begin
              state_next = HSPS_IDLE;
            end
          end else begin
            tmr_next = tmr_reg + 1'b1;
          end
        end
      end
      default: begin
        state_next = HSPS_IDLE;
        tmr_next   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg      <= HSPS_IDLE;
      tmr_reg        <= '0;
      gate_reg       <= 1'b0;                                                // [RQ20]
      pg_n_reg       <= 1'b1;                                                // [RQ20]
      fault_n_reg    <= 1'b1;                                                // [RQ20]
      start_trip_reg <= 1'b0;
      trip_cnt_reg   <= '0;
    end else begin
      state_reg      <= state_next;
      tmr_reg        <= tmr_next;
      gate_reg       <= gate_next;
      pg_n_reg       <= pg_n_next;
      fault_n_reg    <= fault_n_next;
      start_trip_reg <= start_trip_next;
      trip_cnt_reg   <= trip_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait cycle per access keeps read data registered
  logic        acc;
  logic        wr_ok;
  logic [31:0] status_word;

  always_comb begin
    acc   = (avs_read | avs_write) & wait_reg;
    wr_ok = avs_write & ~wait_reg;
    status_word                                      = '0;
    status_word[4:0]                                 = state_reg;
    status_word[ST_TRIP_EVT]                         = trip_evt_reg;
    status_word[ST_START_TRIP]                       = start_trip_reg;
    status_word[ST_GATE]                             = gate_reg;
    status_word[ST_PGOOD]                            = ~pg_n_reg;
    status_word[ST_FAULT]                            = ~fault_n_reg;
    status_word[ST_CNT_LSB +: TRIP_CNT_W]            = trip_cnt_reg;
  end

  always_comb begin
    wait_next     = ~acc;
    rdata_next    = rdata_reg;
    ctrl_next     = ctrl_reg;
    trip_evt_next = trip_evt_reg;
    if (acc && avs_read) begin
      case (avs_address)
        OFS_CTRL:   rdata_next = {29'h0000000, ctrl_reg};
        OFS_STATUS: rdata_next = status_word;
        OFS_CONFIG: rdata_next = {28'h0000000, PGD_SEL, FILT_SEL};
        default:    rdata_next = 32'h00000000;
      endcase
    end
    if (wr_ok && avs_byteenable[0]) begin
      if (avs_address == OFS_CTRL) begin
        ctrl_next = avs_writedata[2:0];
      end
    end
    if (wr_ok && avs_byteenable[1] && avs_address == OFS_STATUS
        && avs_writedata[ST_TRIP_EVT]) begin
      trip_evt_next = 1'b0;
    end
    // A trip in the clearing cycle wins over the clear
    if (state_reg != HSPS_TRIP && state_next == HSPS_TRIP) begin
      trip_evt_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      wait_reg     <= 1'b1;
      rdata_reg    <= 32'h00000000;
      ctrl_reg     <= CTRL_RESET;
      trip_evt_reg <= 1'b0;
    end else begin
      wait_reg     <= wait_next;
      rdata_reg    <= rdata_next;
      ctrl_reg     <= ctrl_next;
      trip_evt_reg <= trip_evt_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign gate_drive_enable_o = gate_reg;
  assign power_good_n_o      = pg_n_reg;
  assign breaker_fault_n_o   = fault_n_reg;
  assign avs_readdata        = rdata_reg;
  assign avs_waitrequest     = wait_reg;

endmodule

// *** verification/hsps_card_model.sv ***
// Card load and backplane supply model facing the power sequencer
`timescale 1ns/100ps
module hsps_card_model
  import hsps_pkg::*;
(
  // Clock
  input  logic       ref_clk_i,
  // Gate and bench knobs
  input  logic       gate_i,
  input  logic [3:0] ramp_i,
  input  hsps_in_t   knob_i,
  // Pins to the sequencer
  output hsps_in_t   pins_o = '0
);
  logic [3:0] ramp_reg = 4'h0;
  logic [3:0] ramp_next;
  hsps_in_t   pins_next;
  always_comb begin
    ramp_next = gate_i ? ramp_reg + {3'h0, ramp_reg != ramp_i} : 4'h0;
    pins_next = knob_i;
    // Drain falls only once the switch has slewed on; ramp_i sets how slowly
    pins_next.switch_on_sense = gate_i && (ramp_reg == ramp_i);
    // No load current can flow while the switch is off
    pins_next.current_drop_sense = knob_i.current_drop_sense && gate_i;
    pins_next.fast_trip = knob_i.fast_trip && gate_i;
  end
  always_ff @(posedge ref_clk_i) begin
    ramp_reg <= ramp_next;
    pins_o   <= pins_next;
  end
endmodule

// *** verification/hsps_top_asserts.sv ***
// Port-level assertion checker for the hot-swap power sequencer
`timescale 1ns/100ps
module hsps_top_asserts
  import hsps_pkg::*;
#(
  parameter int SEAT_LIM = 20,
  parameter int FILT_LIM = 8
) (
  // Clock and reset
  input logic ref_clk_i,
  input logic reset_n_i,
  // Comparator and card inputs
  input logic supply_low_compare_i,
  input logic supply_high_compare_i,
  input logic seat_detect_a_n_i,
  input logic seat_detect_b_n_i,
  input logic switch_on_sense_i,
  input logic current_drop_sense_i,
  input logic fast_trip_i,
  input logic breaker_clear_n_i,
  // Sequencer outputs
  input logic gate_drive_enable_o,
  input logic power_good_n_o,
  input logic breaker_fault_n_o,
  input logic avs_waitrequest
);
  // ------
  // Run counters
  // ------
  logic ok;
  int   ok_run_reg;
  int   ok_run_next;
  int   drop_run_reg;
  int   drop_run_next;
  assign ok = supply_low_compare_i && !supply_high_compare_i && !seat_detect_a_n_i &&
              !seat_detect_b_n_i && breaker_clear_n_i;
  // Counted at the pins, so they lead the synchronised view by two cycles
  always_comb begin
    ok_run_next   = ok ? ok_run_reg + 1 : 0;
    drop_run_next = (current_drop_sense_i && gate_drive_enable_o) ? drop_run_reg + 1 : 0;
  end
  always_ff @(posedge ref_clk_i) begin
    ok_run_reg   <= reset_n_i ? ok_run_next : 0;
    drop_run_reg <= reset_n_i ? drop_run_next : 0;
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_idle: assert property ($rose(reset_n_i) |->
    !gate_drive_enable_o && power_good_n_o && breaker_fault_n_o && avs_waitrequest)
    else $error("outputs not idle after reset");
  a_seat_min: assert property ($rose(gate_drive_enable_o) |-> ok_run_reg >= SEAT_LIM)
    else $error("gate rose before seat delay");
  a_seat_max: assert property (ok_run_reg == SEAT_LIM + 6 && breaker_fault_n_o |->
    gate_drive_enable_o) else $error("gate late after seat delay");
  a_window_off: assert property (!ok [*5] |-> !gate_drive_enable_o)
    else $error("gate on without enabling conditions");
  a_pg_switch: assert property (!switch_on_sense_i [*5] |-> power_good_n_o)
    else $error("power good without switch on");
  a_pg_gate: assert property (!power_good_n_o && $past(!power_good_n_o) |->
    gate_drive_enable_o) else $error("power good without gate");
  a_filter_bound: assert property (drop_run_reg <= FILT_LIM + 4)
    else $error("sustained drop not tripped");
  a_fast_trip: assert property (fast_trip_i && gate_drive_enable_o |->
    ##[1:4] !gate_drive_enable_o && !breaker_fault_n_o) else $error("fast trip missed");
  a_trip_gate: assert property ($fell(breaker_fault_n_o) |-> !gate_drive_enable_o)
    else $error("fault with gate on");
  c_trip: cover property ($fell(breaker_fault_n_o));
  c_retry: cover property ($rose(breaker_fault_n_o));
  c_pgood: cover property ($fell(power_good_n_o));
endmodule

// Filter limit follows the default filter select of 3
bind hsps_top hsps_top_asserts #(.SEAT_LIM(SEAT_CYC), .FILT_LIM(FILT3)) i_chk (.*);

// *** verification/tb_top.sv ***
// Self-checking testbench for the hot-swap power sequencer
`timescale 1ns/100ps
module tb_top;
  import hsps_pkg::*;
  localparam int SEAT = 20;
  localparam int RETRY = 50;
  localparam int FILT = 8;
  localparam int PGD = 10;
  localparam int G = 2;
  localparam int P = 1;
  localparam int F = 0;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_r;
  logic [3:0]  ramp = 4'h2;
  hsps_in_t    knob = 8'hb1;
  hsps_in_t    pins;
  wire  [2:0]  outs;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  hsps_card_model i_card (.ref_clk_i(ref_clk_i), .gate_i(outs[G]), .ramp_i(ramp),
    .knob_i(knob), .pins_o(pins));
  hsps_top #(.SEAT_CYC(SEAT), .RETRY_PER(RETRY), .FILT3(FILT), .PGD0(PGD)) i_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .supply_low_compare_i(pins.supply_low_compare),
    .supply_high_compare_i(pins.supply_high_compare),
    .seat_detect_a_n_i(pins.seat_detect_a_n), .seat_detect_b_n_i(pins.seat_detect_b_n),
    .switch_on_sense_i(pins.switch_on_sense), .current_drop_sense_i(pins.current_drop_sense),
    .fast_trip_i(pins.fast_trip), .breaker_clear_n_i(pins.breaker_clear_n),
    .gate_drive_enable_o(outs[G]), .power_good_n_o(outs[P]), .breaker_fault_n_o(outs[F]),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_r));
  // ------
  // Tasks
  // ------
  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic in_win(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk_i);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    do @(posedge ref_clk_i); while (wait_r !== 1'b0);
    q  = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_out(input int b, input logic v, output int n);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (outs[b] !== v);
  endtask
  task automatic power_on(input int pg_lo);
    int n;
    wait_out(G, 1'b1, n);
    check(in_win(n, SEAT + 1, SEAT + 7), 1'b1);
    wait_out(P, 1'b0, n);
    check(in_win(n, pg_lo, pg_lo + 6), 1'b1);
  endtask
  // Hang guard well above the run length
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ------
  // Scenarios
  // ------
  initial begin
    logic [31:0] q;
    int          n;
    void'($urandom(32'h73b85dd4));
    cycles(3);
    reset_n_i <= 1'b1;
    check({29'h0, outs}, 32'h3);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    check(q, 32'h5);
    bus(1'b1, OFS_CONFIG, $urandom(), q);
    bus(1'b1, 4'hc, $urandom(), q);
    bus(1'b0, OFS_CONFIG, 32'h0, q);
    check(q, 32'h3);
    bus(1'b0, 4'hc, 32'h0, q);
    check(q, 32'h0);
    cycles(SEAT + 8);
    check({29'h0, outs}, 32'h3);
    knob.seat_detect_a_n <= 1'b0;
    knob.seat_detect_b_n <= 1'b0;
    power_on(PGD - 1);
    bus(1'b1, OFS_STATUS, 32'h100, q);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    check(q & 32'h071f, 32'h0408);
    repeat (20) begin
      knob.current_drop_sense <= 1'b1;
      cycles(1 + $urandom_range(FILT - 4));
      knob.current_drop_sense <= 1'b0;
      cycles(FILT + $urandom_range(4));
    end
    check({29'h0, outs}, 32'h5);
    knob.current_drop_sense <= 1'b1;
    wait_out(F, 1'b0, n);
    check(in_win(n, FILT + 2, FILT + 7), 1'b1);
    check({outs[G], outs[F]}, 2'h0);
    cycles(RETRY + 8);
    check({29'h0, outs}, 32'h2);
    knob.current_drop_sense <= 1'b0;
    knob.breaker_clear_n <= 1'b0;
    cycles(SEAT + 8);
    check({29'h0, outs}, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h7, q);
    knob.breaker_clear_n <= 1'b1;
    wait_out(G, 1'b1, n);
    check(in_win(n, SEAT + 1, SEAT + 7), 1'b1);
    knob.fast_trip <= 1'b1;
    wait_out(F, 1'b0, n);
    check(in_win(n, 2, 6), 1'b1);
    bus(1'b1, OFS_STATUS, 32'h100, q);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    check(q & 32'hff071f, 32'h020210);
    cycles(PGD - 2);
    check({29'h0, outs}, 32'h2);
    wait_out(F, 1'b1, n);
    check(in_win(n, RETRY - PGD - 6, RETRY - PGD - 2), 1'b1);
    wait_out(F, 1'b0, n);
    check(in_win(n, 2, 7), 1'b1);
    knob.fast_trip <= 1'b0;
    wait_out(F, 1'b1, n);
    wait_out(P, 1'b0, n);
    check(in_win(n, PGD - 1, PGD + 6), 1'b1);
    ramp <= 4'hf;
    for (int i = 0; i < 2; i++) begin
      knob.supply_low_compare <= (i != 0);
      knob.supply_high_compare <= (i != 0);
      wait_out(G, 1'b0, n);
      check(in_win(n, 2, 6), 1'b1);
      cycles(2);
      check(outs[P], 1'b1);
      knob.supply_low_compare <= 1'b1;
      knob.supply_high_compare <= 1'b0;
      power_on(16);
    end
    stop_test();
  end
endmodule
